// file: hdl/sfs_top.sv
// Serial flash command engine: status writes on the core clock, reads on the serial clock
`timescale 1ns/1ns
module sfs_top import sfs_pkg::*; #(
  parameter int ARRAY_AW = 22
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_sck,
  input wire logic i_cs_b,
  input wire logic i_io_0,
  input wire logic i_io_1,
  input wire logic i_io_2,
  input wire logic i_io_3,
  output logic o_io_0,
  output logic o_io_1,
  output logic o_io_2,
  output logic o_io_3,
  output logic o_io_0_oe,
  output logic o_io_1_oe,
  output logic o_io_2_oe,
  output logic o_io_3_oe,
  input wire logic i_four_wire_mode,
  input wire logic i_load_en,
  input wire logic [ARRAY_AW-1:0] i_load_addr,
  input wire logic [7:0] i_load_data,
  output logic [7:0] o_status_low,
  output logic [7:0] o_status_high
);
  // ---------------- Serial clock domain ----------------
  // Frame logic clears while chip select is high; the snapshot
  // registers below keep the last frame for the core domain.
  logic frame_rst_b;
  assign frame_rst_b = i_rst_b & ~i_cs_b;

  logic [15:0] stat_meta_ff;
  logic [15:0] stat_mid_ff;
  logic [15:0] stat_late_ff;
  logic [15:0] stat_sync_ff;
  logic mode_meta_ff;
  logic mode_mid_ff;
  logic mode_late_ff;
  logic mode_sync_ff;
  logic [15:0] status_word;

  sfs_lstate_t st_ff;
  sfs_lstate_t nxt_st;
  logic [4:0] pcnt_ff;
  logic [4:0] nxt_pcnt;
  logic [7:0] cmd_ff;
  logic [7:0] nxt_cmd;
  logic [23:0] addr_ff;
  logic [23:0] nxt_addr;
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  logic in2_ff;
  logic nxt_in2;
  logic has_mode_ff;
  logic nxt_has_mode;
  logic has_dummy_ff;
  logic nxt_has_dummy;
  logic [1:0] olane_ff;
  logic [1:0] nxt_olane;
  logic [2:0] dcnt_ff;
  logic [2:0] nxt_dcnt;
  logic [23:0] rd_addr_ff;
  logic [23:0] nxt_rd_addr;
  logic sel_high_ff;
  logic nxt_sel_high;
  logic cont_ff;
  logic nxt_cont;
  logic cmd_done;
  logic mem_re;
  logic [23:0] mem_raddr;

  logic [7:0] snap_cmd_ff;
  logic [4:0] snap_len_ff;
  logic [15:0] snap_data_ff;
  logic snap_seq_ff;

  logic [7:0] out_sr_ff;
  logic [3:0] pins_ff;
  logic [3:0] oe_ff;
  logic [7:0] mem_q;

  always_ff @(posedge i_sck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_meta_ff <= 16'h0000;
      stat_mid_ff <= 16'h0000;
      stat_late_ff <= 16'h0000;
      stat_sync_ff <= 16'h0000;
      mode_meta_ff <= 1'h0;
      mode_mid_ff <= 1'h0;
      mode_late_ff <= 1'h0;
      mode_sync_ff <= 1'h0;
    end else begin
      stat_meta_ff <= status_word;
      stat_mid_ff <= stat_meta_ff;
      stat_late_ff <= stat_mid_ff;
      // Whole word taken only when two samples agree, so no torn status
      if (stat_mid_ff == stat_late_ff) begin
        stat_sync_ff <= stat_late_ff;
      end
      mode_meta_ff <= i_four_wire_mode;
      mode_mid_ff <= mode_meta_ff;
      mode_late_ff <= mode_mid_ff;
      if (mode_mid_ff == mode_late_ff) begin
        mode_sync_ff <= mode_late_ff;
      end
    end
  end

  logic wip_s;
  logic qe_s;
  logic [7:0] cmd_full;
  logic [23:0] addr_shift;
  logic [7:0] mode_full;
  logic addr_last;
  logic [2:0] dcnt_last;
  logic cmd_is_read;
  logic read_ok;
  logic [23:0] rd_next;
  assign wip_s = stat_sync_ff[WIP_POS];
  assign qe_s = stat_sync_ff[8+QE_POS];
  assign cmd_full = {cmd_ff[6:0], i_io_0};
  // Dual entry: io_line_1 carries the odd (higher) bit of each pair
  assign addr_shift = in2_ff ? {addr_ff[21:0], i_io_1, i_io_0} : {addr_ff[22:0], i_io_0};
  assign mode_full = {mode_ff[5:0], i_io_1, i_io_0};
  assign addr_last = in2_ff ? (pcnt_ff == ADDR_LAST_2) : (pcnt_ff == ADDR_LAST_1);
  assign dcnt_last = (olane_ff == LANE_4) ? 3'h1 : ((olane_ff == LANE_2) ? 3'h3 : 3'h7);
  assign rd_next = rd_addr_ff + 24'h00_0001;
  assign cmd_is_read = (cmd_full == CMD_READ) || (cmd_full == CMD_FAST_READ) ||
                       (cmd_full == CMD_DUAL_OUT_READ) || (cmd_full == CMD_QUAD_OUT_READ) ||
                       (cmd_full == CMD_DUAL_IO_READ);
  assign read_ok = !wip_s &&
                   !((cmd_full == CMD_READ) && mode_sync_ff) &&
                   !((cmd_full == CMD_QUAD_OUT_READ) && !qe_s);

  always_comb begin
    nxt_st = st_ff;
    nxt_pcnt = pcnt_ff + 5'h01;
    nxt_cmd = cmd_ff;
    nxt_addr = addr_ff;
    nxt_mode = mode_ff;
    nxt_in2 = in2_ff;
    nxt_has_mode = has_mode_ff;
    nxt_has_dummy = has_dummy_ff;
    nxt_olane = olane_ff;
    nxt_dcnt = dcnt_ff;
    nxt_rd_addr = rd_addr_ff;
    nxt_sel_high = sel_high_ff;
    nxt_cont = cont_ff;
    cmd_done = 1'h0;
    mem_re = 1'h0;
    mem_raddr = rd_addr_ff;
    case (st_ff)
      LS_CMD: begin
        if (cont_ff) begin
          // Continuous mode: first clock already carries an address pair
          nxt_addr = {addr_ff[21:0], i_io_1, i_io_0};
          nxt_in2 = 1'h1;
          nxt_has_mode = 1'h1;
          nxt_has_dummy = 1'h0;
          nxt_olane = LANE_2;
          nxt_st = LS_ADDR;
          // Cut frame leaves normal decoding; full mode phase may re-arm it
          nxt_cont = 1'h0;
        end else begin
          nxt_cmd = cmd_full;
          if (pcnt_ff == CMD_LAST) begin
            cmd_done = 1'h1;
            nxt_pcnt = 5'h00;
            nxt_in2 = (cmd_full == CMD_DUAL_IO_READ);
            nxt_has_mode = (cmd_full == CMD_DUAL_IO_READ);
            nxt_has_dummy = (cmd_full != CMD_READ) && (cmd_full != CMD_DUAL_IO_READ);
            nxt_olane = (cmd_full == CMD_QUAD_OUT_READ) ? LANE_4 :
                        ((cmd_full == CMD_DUAL_OUT_READ) || (cmd_full == CMD_DUAL_IO_READ)) ?
                        LANE_2 : LANE_1;
            nxt_sel_high = (cmd_full == CMD_STATUS_READ_HIGH);
            nxt_dcnt = 3'h0;
            if (cmd_is_read) begin
              nxt_st = read_ok ? LS_ADDR : LS_IDLE;
            end else if ((cmd_full == CMD_STATUS_READ_LOW) ||
                         (cmd_full == CMD_STATUS_READ_HIGH)) begin
              nxt_olane = LANE_1;
              nxt_st = LS_STAT;
            end else if ((cmd_full == CMD_STATUS_WRITE_LOW) ||
                         (cmd_full == CMD_STATUS_WRITE_HIGH)) begin
              nxt_st = LS_WDATA;
            end else begin
              nxt_st = LS_IDLE;
            end
          end
        end
      end
      LS_ADDR: begin
        nxt_addr = addr_shift;
        if (addr_last) begin
          nxt_pcnt = 5'h00;
          nxt_rd_addr = addr_shift;
          if (has_mode_ff) begin
            nxt_st = LS_MODE;
          end else if (has_dummy_ff) begin
            nxt_st = LS_DUMMY;
          end else begin
            mem_re = 1'h1;
            mem_raddr = addr_shift;
            nxt_dcnt = 3'h0;
            nxt_st = LS_DATA;
          end
        end
      end
      LS_MODE: begin
        nxt_mode = mode_full;
        if (pcnt_ff == MODE_LAST_2) begin
          // Only bits 5..4 matter; the low nibble is don't care
          nxt_cont = (mode_full[5:4] == CONT_MODE_CODE);
          mem_re = 1'h1;
          nxt_dcnt = 3'h0;
          nxt_st = LS_DATA;
        end
      end
      LS_DUMMY: begin
        // Input lines are not looked at here
        if (pcnt_ff == DUMMY_LAST) begin
          mem_re = 1'h1;
          nxt_dcnt = 3'h0;
          nxt_st = LS_DATA;
        end
      end
      LS_DATA: begin
        if (dcnt_ff == dcnt_last) begin
          nxt_dcnt = 3'h0;
          nxt_rd_addr = rd_next;
          mem_re = 1'h1;
          mem_raddr = rd_next;
        end else begin
          nxt_dcnt = dcnt_ff + 3'h1;
        end
      end
      LS_STAT: begin
        nxt_dcnt = dcnt_ff + 3'h1;
      end
      LS_WDATA: begin
        nxt_pcnt = pcnt_ff;
      end
      LS_IDLE: begin
        nxt_pcnt = pcnt_ff;
      end
      default: begin
        nxt_st = LS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sck or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      st_ff <= LS_CMD;
      pcnt_ff <= 5'h00;
      cmd_ff <= 8'h00;
      addr_ff <= 24'h00_0000;
      mode_ff <= 8'h00;
      in2_ff <= 1'h0;
      has_mode_ff <= 1'h0;
      has_dummy_ff <= 1'h0;
      olane_ff <= LANE_1;
      dcnt_ff <= 3'h0;
      rd_addr_ff <= 24'h00_0000;
      sel_high_ff <= 1'h0;
    end else begin
      st_ff <= nxt_st;
      pcnt_ff <= nxt_pcnt;
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      mode_ff <= nxt_mode;
      in2_ff <= nxt_in2;
      has_mode_ff <= nxt_has_mode;
      has_dummy_ff <= nxt_has_dummy;
      olane_ff <= nxt_olane;
      dcnt_ff <= nxt_dcnt;
      rd_addr_ff <= nxt_rd_addr;
      sel_high_ff <= nxt_sel_high;
    end
  end

  // Snapshot of the last command; held while the clock stands after the frame
  always_ff @(posedge i_sck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cont_ff <= 1'h0;
      snap_cmd_ff <= 8'h00;
      snap_len_ff <= 5'h00;
      snap_data_ff <= 16'h0000;
      snap_seq_ff <= 1'h0;
    end else begin
      cont_ff <= nxt_cont;
      if (cmd_done) begin
        snap_cmd_ff <= cmd_full;
        snap_len_ff <= 5'h00;
        snap_seq_ff <= ~snap_seq_ff;
      end else if ((st_ff != LS_CMD) && (snap_len_ff != LEN_SAT)) begin
        snap_len_ff <= snap_len_ff + 5'h01;
      end
      if (st_ff == LS_WDATA) begin
        snap_data_ff <= {snap_data_ff[14:0], i_io_0};
      end
    end
  end

  sfs_mem #(
    .AW(ARRAY_AW)
  ) u_mem (
    .i_wr_clk(i_ref_clk),
    .i_wr_en(i_load_en),
    .i_wr_addr(i_load_addr),
    .i_wr_data(i_load_data),
    .i_rd_clk(i_sck),
    .i_rd_en(mem_re),
    .i_rd_addr(mem_raddr[ARRAY_AW-1:0]),
    .o_rd_data(mem_q)
  );

  // Output stage on the falling edge, one lane group per clock
  logic [7:0] load_val;
  logic [7:0] shifted;
  logic [7:0] nxt_sr;
  logic [3:0] nxt_pins;
  logic [3:0] nxt_oe;
  logic shifting;
  assign shifting = (st_ff == LS_DATA) || (st_ff == LS_STAT);
  assign load_val = (st_ff == LS_STAT) ?
                    (sel_high_ff ? stat_sync_ff[15:8] : stat_sync_ff[7:0]) : mem_q;
  assign shifted = (olane_ff == LANE_4) ? {out_sr_ff[3:0], 4'h0} :
                   (olane_ff == LANE_2) ? {out_sr_ff[5:0], 2'h0} : {out_sr_ff[6:0], 1'h0};
  assign nxt_sr = (dcnt_ff == 3'h0) ? load_val : shifted;
  assign nxt_pins = (olane_ff == LANE_4) ? nxt_sr[7:4] :
                    (olane_ff == LANE_2) ? {2'h0, nxt_sr[7], nxt_sr[6]} :
                    {2'h0, nxt_sr[7], 1'h0};
  assign nxt_oe = (olane_ff == LANE_4) ? 4'hF : ((olane_ff == LANE_2) ? 4'h3 : 4'h2);

  always_ff @(negedge i_sck or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      out_sr_ff <= 8'h00;
      pins_ff <= 4'h0;
      oe_ff <= 4'h0;
    end else if (shifting) begin
      out_sr_ff <= nxt_sr;
      pins_ff <= nxt_pins;
      oe_ff <= nxt_oe;
    end else begin
      oe_ff <= 4'h0;
    end
  end

  assign o_io_0 = pins_ff[0];
  assign o_io_1 = pins_ff[1];
  assign o_io_2 = pins_ff[2];
  assign o_io_3 = pins_ff[3];
  assign o_io_0_oe = oe_ff[0];
  assign o_io_1_oe = oe_ff[1];
  assign o_io_2_oe = oe_ff[2];
  assign o_io_3_oe = oe_ff[3];

  // ---------------- Core clock domain ----------------
  logic cs_meta_ff;
  logic [1:0] cs_sync_ff;
  logic cs_filt_ff;
  logic seen_seq_ff;
  logic [7:0] nv_low_ff;
  logic [7:0] nv_high_ff;
  logic [7:0] cur_low_ff;
  logic [7:0] cur_high_ff;
  logic wel_ff;
  logic wip_ff;
  logic vol_en_ff;
  logic [15:0] tw_cnt_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_meta_ff <= 1'h1;
      cs_sync_ff <= CS_SYNC_RESET;
      cs_filt_ff <= 1'h1;
    end else begin
      cs_meta_ff <= i_cs_b;
      cs_sync_ff <= {cs_sync_ff[0], cs_meta_ff};
      if (cs_sync_ff[0] == cs_sync_ff[1]) begin
        cs_filt_ff <= cs_sync_ff[0];
      end
    end
  end

  // Snapshot is only read on the detected rise, while the serial clock stands
  logic cs_rise;
  logic exec;
  logic plain;
  logic len_ok;
  logic do_wren;
  logic do_vol_en;
  logic do_wrdis;
  logic do_reset;
  logic sw_any;
  logic sw_nv;
  logic sw_vol;
  logic short_low;
  logic [7:0] low_in;
  logic [7:0] high_in;
  logic [7:0] high_guard;
  logic [7:0] new_low;
  logic [7:0] new_high;
  logic tw_done;
  assign cs_rise = cs_sync_ff[0] && cs_sync_ff[1] && !cs_filt_ff;
  assign exec = cs_rise && (snap_seq_ff != seen_seq_ff);
  assign plain = (snap_len_ff == 5'h00);
  assign do_wren = exec && plain && !wip_ff && (snap_cmd_ff == CMD_WRITE_ENABLE);
  assign do_vol_en = exec && plain && !wip_ff && (snap_cmd_ff == CMD_VOL_ENABLE);
  assign do_wrdis = exec && plain && !wip_ff && (snap_cmd_ff == CMD_WRITE_DISABLE);
  assign do_reset = exec && plain && !wip_ff && (snap_cmd_ff == CMD_SOFT_RESET);
  assign short_low = (snap_cmd_ff == CMD_STATUS_WRITE_LOW) && (snap_len_ff == LEN_SHORT);
  assign len_ok = ((snap_cmd_ff == CMD_STATUS_WRITE_LOW) &&
                   ((snap_len_ff == LEN_SHORT) || (snap_len_ff == LEN_LONG))) ||
                  ((snap_cmd_ff == CMD_STATUS_WRITE_HIGH) && (snap_len_ff == LEN_SHORT));
  assign sw_any = exec && len_ok && !wip_ff;
  assign sw_vol = sw_any && vol_en_ff;
  assign sw_nv = sw_any && !vol_en_ff && wel_ff;
  assign low_in = (snap_cmd_ff != CMD_STATUS_WRITE_LOW) ? cur_low_ff :
                  (short_low ? snap_data_ff[7:0] : snap_data_ff[15:8]);
  assign high_in = (snap_cmd_ff == CMD_STATUS_WRITE_HIGH) ? snap_data_ff[7:0] :
                   (short_low ? (cur_high_ff & ~SHORT_CLEAR_MASK) : snap_data_ff[7:0]);
  // The lock bit that is already set survives, protect lock 1 too on volatile writes, and quad_enable holds in four-wire mode
  assign high_guard = cur_high_ff & (LOCK_BIT_MASK |
                                     (sw_vol ? PROTECT_LOCK_1_MASK : 8'h00) |
                                     (i_four_wire_mode ? QUAD_ENABLE_MASK : 8'h00));
  assign new_low = sfs_merge(cur_low_ff, low_in, LOW_WRITE_MASK);
  assign new_high = sfs_merge(cur_high_ff, high_in, HIGH_WRITE_MASK) | high_guard;
  assign tw_done = wip_ff && (tw_cnt_ff == 16'h0000);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seen_seq_ff <= 1'h0;
      nv_low_ff <= NV_LOW_RESET;
      nv_high_ff <= NV_HIGH_RESET;
      cur_low_ff <= NV_LOW_RESET;
      cur_high_ff <= NV_HIGH_RESET;
      vol_en_ff <= 1'h0;
    end else begin
      if (exec) begin
        seen_seq_ff <= snap_seq_ff;
        vol_en_ff <= do_vol_en;
      end
      if (sw_nv) begin
        nv_low_ff <= new_low;
        nv_high_ff <= new_high;
      end
      if (do_reset) begin
        cur_low_ff <= nv_low_ff;
        cur_high_ff <= nv_high_ff;
      end else if (sw_nv || sw_vol) begin
        cur_low_ff <= new_low;
        cur_high_ff <= new_high;
      end
    end
  end

  // Self-timed cycle; write_latch falls when it ends, or on write disable or soft reset
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wip_ff <= 1'h0;
      wel_ff <= 1'h0;
      tw_cnt_ff <= 16'h0000;
    end else begin
      if (sw_nv) begin
        wip_ff <= 1'h1;
        tw_cnt_ff <= 16'(TW_CYCLES - 1);
      end else if (tw_done) begin
        wip_ff <= 1'h0;
      end else if (wip_ff) begin
        tw_cnt_ff <= tw_cnt_ff - 16'h0001;
      end
      if (do_wren) begin
        wel_ff <= 1'h1;
      end else if (do_wrdis || do_reset || tw_done) begin
        wel_ff <= 1'h0;
      end
    end
  end

  assign o_status_low = {cur_low_ff[7:2], wel_ff, wip_ff};
  assign o_status_high = cur_high_ff;
  assign status_word = {o_status_high, o_status_low};
endmodule

// file: hdl/sfs_pkg.sv
// Constants, types and helpers for the serial flash status write and read block
package sfs_pkg;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_VOL_ENABLE = 8'h50;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h99;
  localparam logic [7:0] CMD_STATUS_WRITE_LOW = 8'h01;
  localparam logic [7:0] CMD_STATUS_WRITE_HIGH = 8'h31;
  localparam logic [7:0] CMD_STATUS_READ_LOW = 8'h05;
  localparam logic [7:0] CMD_STATUS_READ_HIGH = 8'h35;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] CMD_QUAD_OUT_READ = 8'h6B;
  localparam logic [7:0] CMD_DUAL_IO_READ = 8'hBB;
  // Status field positions and masks
  localparam int WIP_POS = 0;
  localparam int WEL_POS = 1;
  localparam int QE_POS = 1;
  localparam logic [7:0] LOW_WRITE_MASK = 8'hFC;
  localparam logic [7:0] HIGH_WRITE_MASK = 8'h5F;
  localparam logic [7:0] LOCK_BIT_MASK = 8'h04;
  localparam logic [7:0] PROTECT_LOCK_1_MASK = 8'h01;
  localparam logic [7:0] QUAD_ENABLE_MASK = 8'h02;
  localparam logic [7:0] SHORT_CLEAR_MASK = 8'h5A;
  localparam logic [7:0] NV_LOW_RESET = 8'h00;
  localparam logic [7:0] NV_HIGH_RESET = 8'h00;
  // Frame geometry
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST_1 = 5'h17;
  localparam logic [4:0] ADDR_LAST_2 = 5'h0B;
  localparam logic [4:0] MODE_LAST_2 = 5'h03;
  localparam logic [4:0] DUMMY_LAST = 5'h07;
  localparam logic [4:0] LEN_SHORT = 5'h08;
  localparam logic [4:0] LEN_LONG = 5'h10;
  localparam logic [4:0] LEN_SAT = 5'h1F;
  localparam logic [1:0] CONT_MODE_CODE = 2'h2;
  localparam logic [1:0] LANE_1 = 2'h0;
  localparam logic [1:0] LANE_2 = 2'h1;
  localparam logic [1:0] LANE_4 = 2'h2;
  // Timing
  localparam int REF_CLK_NS = 10;
  localparam int TW_NS = 10000;
  localparam int TW_CYCLES = (TW_NS + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam logic [1:0] CS_SYNC_RESET = 2'h3;

  typedef enum logic [2:0] {
    LS_CMD, LS_ADDR, LS_MODE, LS_DUMMY, LS_DATA, LS_STAT, LS_WDATA, LS_IDLE
  } sfs_lstate_t;

  function automatic logic [7:0] sfs_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] mask);
    sfs_merge = (old_v & ~mask) | (new_v & mask);
  endfunction
endpackage

// file: hdl/sfs_mem.sv
// Byte array with a write port on the core clock and a registered read port
`timescale 1ns/1ns
module sfs_mem #(
  parameter int AW = 22
) (
  input wire logic i_wr_clk,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_clk,
  input wire logic i_rd_en,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);
  logic [7:0] mem_ff [2**AW];
  logic [7:0] rd_data_ff;

  always_ff @(posedge i_wr_clk) begin
    if (i_wr_en) begin
      mem_ff[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_rd_clk) begin
    if (i_rd_en) begin
      rd_data_ff <= mem_ff[i_rd_addr];
    end
  end

  assign o_rd_data = rd_data_ff;
endmodule

// file: tb/sfs_props.sv
// Status and line-enable properties of the flash engine
`timescale 1ns/1ns
module sfs_props import sfs_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_b,
  input wire logic o_io_0_oe,
  input wire logic o_io_1_oe,
  input wire logic o_io_2_oe,
  input wire logic o_io_3_oe,
  input wire logic [7:0] o_status_low,
  input wire logic [7:0] o_status_high
);
  logic [10:0] busy_ff;
  logic [10:0] nxt_busy;
  assign nxt_busy = o_status_low[0] ? busy_ff + 11'h001 : 11'h000;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_ff <= 11'h000;
    end else begin
      busy_ff <= nxt_busy;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  a_oe_idle_off: assert property (i_cs_b && $past(i_cs_b) |->
    !(o_io_0_oe | o_io_1_oe | o_io_2_oe | o_io_3_oe)) else $error("line driven while idle");
  a_busy_len: assert property ($fell(o_status_low[0]) |-> busy_ff == 11'(TW_CYCLES))
    else $error("busy time wrong");
  a_wel_end: assert property ($fell(o_status_low[0]) |-> !o_status_low[1])
    else $error("write latch kept");
  a_busy_wel: assert property ($rose(o_status_low[0]) |-> o_status_low[1] && $past(i_cs_b))
    else $error("busy without latch");
  a_lock_kept: assert property ($past(o_status_high[2]) |-> o_status_high[2])
    else $error("lock bit cleared");
  a_fixed_bits: assert property ((o_status_high & 8'hA0) == 8'h00)
    else $error("fixed bit changed");
  a_vol_no_busy: assert property ($changed(o_status_high) && !o_status_low[1] |->
    !o_status_low[0]) else $error("busy on volatile write");
  a_sel_stable: assert property (!i_cs_b && !$past(i_cs_b, 8) |-> $stable(o_status_high))
    else $error("status changed while selected");
endmodule
bind sfs_top sfs_props chk_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b),
  .o_io_0_oe(o_io_0_oe), .o_io_1_oe(o_io_1_oe), .o_io_2_oe(o_io_2_oe), .o_io_3_oe(o_io_3_oe),
  .o_status_low(o_status_low), .o_status_high(o_status_high));

// file: tb/sfs_host_model.sv
// Behavioural SPI host: chip select, serial clock and four lines
`timescale 1ns/1ns
module sfs_host_model (
  input wire logic [3:0] i_io,
  output logic o_sck,
  output logic o_cs_b,
  output logic [3:0] o_io,
  output logic [3:0] o_oe
);
  initial begin
    o_sck = 1'b0;
    o_cs_b = 1'b1;
    o_io = 4'h0;
    o_oe = 4'h0;
  end
  task automatic begin_f();
    o_cs_b = 1'b0;
    #20;
  endtask
  // Ends the frame at any bit count, then idle well over 80 ns
  task automatic end_f();
    o_oe = 4'h0;
    #10 o_cs_b = 1'b1;
    #120;
  endtask
  // Lines change while the clock is low, sampled just before it rises
  task automatic shift(input int n, input int w, input logic [31:0] d, input bit drv,
                       output logic [31:0] q);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    q = 32'h0;
    for (int k = n - 1; k >= 0; k--) begin
      o_oe = drv ? m : 4'h0;
      o_io = 4'(d >> (k * w)) & m;
      #15 q = (q << w) | ((w == 1) ? {31'h0, i_io[1]} : {28'h0, i_io & m});
      #1 o_sck = 1'b1;
      #16 o_sck = 1'b0;
    end
  endtask
endmodule

// file: tb/sfs_tb_top.sv
// Self-checking bench for the flash status and read engine
`timescale 1ns/1ns
module sfs_tb_top import sfs_pkg::*; ();
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic four_wire = 1'b0;
  logic load_en = 1'b0;
  logic [7:0] load_addr = 8'h00;
  logic [7:0] load_data = 8'h00;
  logic sck;
  logic cs_b;
  logic [3:0] h_io;
  logic [3:0] h_oe;
  logic [3:0] d_io;
  logic [3:0] d_oe;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [31:0] q;
  int fails = 0;
  int n_tests = 0;
  // Released lines follow the inverted clock rather than hold a value
  wire [3:0] ln = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & {4{~sck}});
  always #5 ref_clk = ~ref_clk;
  sfs_host_model host_u (.i_io(ln), .o_sck(sck), .o_cs_b(cs_b), .o_io(h_io), .o_oe(h_oe));
  sfs_top #(.ARRAY_AW(8)) dut_u (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_sck(sck),
    .i_cs_b(cs_b), .i_io_0(ln[0]), .i_io_1(ln[1]), .i_io_2(ln[2]), .i_io_3(ln[3]),
    .o_io_0(d_io[0]), .o_io_1(d_io[1]), .o_io_2(d_io[2]), .o_io_3(d_io[3]),
    .o_io_0_oe(d_oe[0]), .o_io_1_oe(d_oe[1]), .o_io_2_oe(d_oe[2]), .o_io_3_oe(d_oe[3]),
    .i_four_wire_mode(four_wire), .i_load_en(load_en), .i_load_addr(load_addr),
    .i_load_data(load_data), .o_status_low(lo), .o_status_high(hi));
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input int nb, input logic [15:0] d);
    host_u.begin_f();
    host_u.shift(8, 1, {24'h0, c}, 1'b1, q);
    if (nb > 0) begin
      host_u.shift(nb, 1, {16'h0, d}, 1'b1, q);
    end
    host_u.end_f();
  endtask
  // Two bytes from address 8'hFE; dual I/O sends mode bits instead of dummies
  task automatic rd(input logic [7:0] c, input int w, input bit nocmd, input logic [7:0] m);
    int aw;
    aw = (c == CMD_DUAL_IO_READ) ? 2 : 1;
    host_u.begin_f();
    if (!nocmd) begin
      host_u.shift(8, 1, {24'h0, c}, 1'b1, q);
    end
    host_u.shift(24 / aw, aw, 32'h0000_00FE, 1'b1, q);
    if (aw == 2) begin
      host_u.shift(4, 2, {24'h0, m}, 1'b1, q);
    end else if (c != CMD_READ) begin
      host_u.shift(8, 1, 32'h0000_00FF, c == CMD_FAST_READ, q);
    end
    host_u.shift(16 / w, w, 32'h0, 1'b0, q);
    host_u.end_f();
  endtask
  task automatic idle();
    for (int k = 0; lo[0] !== 1'b0; k++) begin
      if (k == 3000) begin
        chk("busy_end", 16'h0000, 16'h0001);
        stop_test();
      end
      @(posedge ref_clk);
    end
  endtask
  task automatic s_nv_write();
    chk("lo_reset", 16'h0000, {hi, lo});
    cmd(CMD_WRITE_ENABLE, 0, 16'h0);
    cmd(CMD_STATUS_WRITE_LOW, 12, 16'h0FFF);
    chk("odd_count", 16'h0002, {hi, lo});
    cmd(CMD_STATUS_WRITE_LOW, 16, 16'hFFFF);
    chk("nv_pair", 16'h5FFF, {hi, lo});
    cmd(CMD_STATUS_READ_LOW, 8, 16'h0);
    chk("busy_status", 16'h00FF, q[15:0]);
    rd(CMD_READ, 1, 1'b0, 8'h00);
    chk("busy_read", 16'hFFFF, q[15:0]);
    cmd(CMD_STATUS_WRITE_LOW, 16, 16'h0000);
    idle();
    chk("nv_done", 16'h5FFC, {hi, lo});
    cmd(CMD_WRITE_ENABLE, 0, 16'h0);
    cmd(CMD_STATUS_WRITE_LOW, 8, 16'h0000);
    idle();
    chk("short", 16'h0500, {hi, lo});
    cmd(CMD_WRITE_ENABLE, 0, 16'h0);
    cmd(CMD_STATUS_WRITE_LOW, 16, 16'h0000);
    idle();
    chk("lock", 16'h0400, {hi, lo});
    cmd(CMD_STATUS_WRITE_LOW, 16, 16'hFFFF);
    chk("no_latch", 16'h0400, {hi, lo});
  endtask
  task automatic s_volatile();
    cmd(CMD_VOL_ENABLE, 0, 16'h0);
    cmd(CMD_STATUS_WRITE_LOW, 16, 16'hFC42);
    chk("vol", 16'h46FC, {hi, lo});
    cmd(CMD_SOFT_RESET, 0, 16'h0);
    chk("soft_reset", 16'h0400, {hi, lo});
    cmd(CMD_VOL_ENABLE, 0, 16'h0);
    cmd(CMD_STATUS_WRITE_HIGH, 8, 16'h0003);
    chk("quad_on", 16'h0700, {hi, lo});
  endtask
  task automatic s_reads();
    logic [7:0] cs [4] = '{CMD_READ, CMD_FAST_READ, CMD_DUAL_OUT_READ, CMD_QUAD_OUT_READ};
    for (int i = 0; i < 4; i++) begin
      rd(cs[i], (i < 2) ? 1 : 2 * (i - 1), 1'b0, 8'h00);
      chk("read", 16'hA4A5, q[15:0]);
    end
    rd(CMD_DUAL_IO_READ, 2, 1'b0, 8'h20);
    chk("dual_io", 16'hA4A5, q[15:0]);
    rd(CMD_DUAL_IO_READ, 2, 1'b1, 8'hFF);
    chk("cont", 16'hA4A5, q[15:0]);
    rd(CMD_READ, 1, 1'b0, 8'h00);
    chk("cont_exit", 16'hA4A5, q[15:0]);
    rd(CMD_DUAL_IO_READ, 2, 1'b0, 8'h20);
    host_u.begin_f();
    host_u.shift(8, 2, 32'h0000_FFFF, 1'b1, q);
    host_u.end_f();
    rd(CMD_READ, 1, 1'b0, 8'h00);
    chk("ones_exit", 16'hA4A5, q[15:0]);
  endtask
  task automatic s_four_wire();
    @(posedge ref_clk);
    four_wire <= 1'b1;
    rd(CMD_READ, 1, 1'b0, 8'h00);
    chk("read_4w", 16'hFFFF, q[15:0]);
    cmd(CMD_VOL_ENABLE, 0, 16'h0);
    cmd(CMD_STATUS_WRITE_LOW, 8, 16'h0000);
    chk("qe_kept", 16'h0700, {hi, lo});
    @(posedge ref_clk);
    four_wire <= 1'b0;
    cmd(CMD_VOL_ENABLE, 0, 16'h0);
    cmd(CMD_STATUS_WRITE_HIGH, 8, 16'h0000);
    chk("pl1_kept", 16'h0500, {hi, lo});
    rd(CMD_QUAD_OUT_READ, 4, 1'b0, 8'h00);
    chk("quad_off", 16'hFFFF, q[15:0]);
  endtask
  // Reset in mid-run while continuous read is armed
  task automatic s_power_up();
    rd(CMD_DUAL_IO_READ, 2, 1'b0, 8'h20);
    chk("pre_rst", 16'hA4A5, q[15:0]);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("rst_status", {NV_HIGH_RESET, NV_LOW_RESET}, {hi, lo});
    rd(CMD_READ, 1, 1'b0, 8'h00);
    chk("rst_cont", 16'hA4A5, q[15:0]);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 256; a++) begin
      @(posedge ref_clk);
      load_en <= 1'b1;
      load_addr <= 8'(a);
      load_data <= 8'(a) ^ 8'h5A;
    end
    @(posedge ref_clk);
    load_en <= 1'b0;
    s_nv_write();
    s_volatile();
    s_reads();
    s_four_wire();
    s_power_up();
    stop_test();
  end
endmodule
